// ---- core/sbc_pkg.sv ----
/*
  sbc_pkg: constants and carrier types for the serial binary-to-bcd converter.
  assumes a single 50 MHz clock domain and synchronous active-high reset.
*/
`default_nettype none
package sbc_pkg;
    localparam int unsigned         SBC_WORD_W    = 12;
    localparam int unsigned         SBC_DECADES   = 4;
    localparam int unsigned         SBC_BCD_W     = 4 * SBC_DECADES;
    localparam int unsigned         SBC_CNT_W     = 4;
    localparam logic [3:0]          SBC_BURST_LEN = 4'hC;
    localparam logic [3:0]          SBC_CNT_ZERO  = 4'h0;
    localparam logic [3:0]          SBC_ADD_LIMIT = 4'h5;
    localparam logic [3:0]          SBC_ADD_VAL   = 4'h3;
    localparam logic [3:0]          SBC_DEC_ZERO  = 4'h0;
    // internal oscillator divider: burst pulse every SBC_OSC_DIV clocks
    localparam int unsigned         SBC_OSC_DIV   = 4;
    localparam int unsigned         SBC_DIV_W     = 2;
    localparam logic [1:0]          SBC_DIV_LAST  = 2'h3;
    localparam logic [1:0]          SBC_DIV_ZERO  = 2'h0;

    typedef enum logic [1:0] {
        SBC_IDLE,
        SBC_CLEAR,
        SBC_LOAD
    } sbc_entry_e;

    typedef struct packed {
        logic                       enter;
        logic                       convert;
        logic                       gray_mode;
        logic                       ext_clk_sel;
        logic                       ext_clk;
        logic                       serial_sel;
        logic                       serial_in;
    } sbc_cmd_s;
endpackage
`default_nettype wire

// ---- core/sbc_decade.sv ----
/*
  sbc_decade: one four-bit decade cell of the shift-and-add-three chain.
  assumes the parent gives a one-cycle step enable and a synchronous clear.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_decade
    import sbc_pkg::*;
(
    // clock and control
    input  wire logic               clock_i,
    input  wire logic               srst_i,
    input  wire logic               clr_i,
    input  wire logic               step_i,
    // serial chain
    input  wire logic               bit_i,
    output logic                    bit_o,
    // contents
    output logic [3:0]              digit_o
);
    logic [3:0] adj;

    always_comb
    begin
        adj = (digit_o >= SBC_ADD_LIMIT) ? digit_o + SBC_ADD_VAL : digit_o;
    end

    assign bit_o = adj[3];

    always_ff @(posedge clock_i)
    begin
        if (srst_i || clr_i)
            digit_o <= SBC_DEC_ZERO;
        else if (step_i)
            digit_o <= {adj[2:0], bit_i};
    end
endmodule
`default_nettype wire

// ---- core/sbc_top.sv ----
/*
  sbc_top: serial binary-to-bcd converter with parallel entry, optional
  gray decoding and a twelve-pulse burst generator.
  assumes command and data inputs may come from pins, so all are synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - enter command loads parallel word, one pulse
// - entry register cleared before load pulse
// - convert clears decades, gray bit, counter; runs
// - pulses while running; stop at count twelve
// - one conversion pulse per input bit
// - each pulse shifts entry bit, or serial pin bit when selected, into decade
// - decade five-plus adds three, then shifts
// - decade carry feeds next decade lsb
// - result held after burst ends
// - gray mode decodes serially before bcd
module sbc_top
    import sbc_pkg::*;
(
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   srst_i,
    // commands and data from upstream
    input  wire sbc_cmd_s               cmd_i,
    input  wire logic [SBC_WORD_W-1:0]  word_i,
    // results
    output logic [SBC_BCD_W-1:0]        bcd_o,
    output logic                        busy_o,
    output logic                        done_o
);
    ////////////////////////////////////////////////////////////////////////
    // shared decodes
    function automatic logic last_pulse(input logic [SBC_CNT_W-1:0] cnt);
        return cnt == SBC_BURST_LEN - 1'b1;
    endfunction

    // a decade fed from a cleared start never leaves 0..9
    function automatic logic is_bcd(input logic [3:0] d);
        return d < (SBC_ADD_LIMIT + SBC_ADD_LIMIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    sbc_cmd_s               cmd_m;
    sbc_cmd_s               cmd_s;
    sbc_cmd_s               cmd_d;
    logic [SBC_WORD_W-1:0]  word_m;
    logic [SBC_WORD_W-1:0]  word_s;

    // two-stage synchroniser plus a delayed copy for edge detect; the first stage is not read
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cmd_m  <= '0;
            cmd_s  <= '0;
            cmd_d  <= '0;
            word_m <= '0;
            word_s <= '0;
        end
        else
        begin
            cmd_m  <= cmd_i;
            cmd_s  <= cmd_m;
            cmd_d  <= cmd_s;
            word_m <= word_i;
            word_s <= cmd_s.enter ? word_s : word_m;
        end
    end

    logic enter_rise;
    logic convert_rise;
    logic ext_rise;
    assign enter_rise   = cmd_s.enter && !cmd_d.enter;
    assign convert_rise = cmd_s.convert && !cmd_d.convert;
    assign ext_rise     = cmd_s.ext_clk && !cmd_d.ext_clk;

    ////////////////////////////////////////////////////////////////////////
    // entry sequencer: clear first, then one load pulse
    sbc_entry_e             entry_st;
    logic [SBC_WORD_W-1:0]  shreg;
    logic                   step;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            entry_st <= SBC_IDLE;
        else
        begin
            case (entry_st)
                SBC_IDLE:  entry_st <= enter_rise ? SBC_CLEAR : SBC_IDLE;
                SBC_CLEAR: entry_st <= SBC_LOAD;
                SBC_LOAD:  entry_st <= SBC_IDLE;
                default:   entry_st <= SBC_IDLE;
            endcase
        end
    end

    // word is frozen while enter is held, so the load sees a stable value
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            shreg <= '0;
        else if (entry_st == SBC_CLEAR)
            shreg <= '0;
        else if (entry_st == SBC_LOAD)
            shreg <= word_s;
        else if (step)
            shreg <= {shreg[SBC_WORD_W-2:0], 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////
    // burst generator
    logic                   run;
    logic [SBC_CNT_W-1:0]   pulse_cnt;
    logic [SBC_DIV_W-1:0]   div;
    logic                   osc_tick;

    assign osc_tick = run && (div == SBC_DIV_LAST);
    // external source must give exactly one pulse per bit
    assign step = run && (cmd_s.ext_clk_sel ? ext_rise : osc_tick);

    always_ff @(posedge clock_i)
    begin
        if (srst_i || convert_rise)
            div <= SBC_DIV_ZERO;
        else if (run)
            div <= div + 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            run       <= 1'b0;
            pulse_cnt <= SBC_CNT_ZERO;
        end
        else if (convert_rise)
        begin
            run       <= 1'b1;
            pulse_cnt <= SBC_CNT_ZERO;
        end
        else if (step)
        begin
            if (last_pulse(pulse_cnt))
            begin
                run       <= 1'b0;
                pulse_cnt <= SBC_CNT_ZERO;
            end
            else
                pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    // independent step tally, read only by the burst length check
    logic [SBC_CNT_W-1:0]   step_seen;

    always_ff @(posedge clock_i)
    begin
        if (srst_i || convert_rise)
            step_seen <= SBC_CNT_ZERO;
        else if (step)
            step_seen <= step_seen + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // serial source and gray decode
    logic src_bit;
    logic gray_state;
    logic ser_bit;

    // serial pin path expects msb first
    assign src_bit = cmd_s.serial_sel ? cmd_s.serial_in : shreg[SBC_WORD_W-1];
    assign ser_bit = cmd_s.gray_mode ? (gray_state ^ src_bit) : src_bit;

    always_ff @(posedge clock_i)
    begin
        if (srst_i || convert_rise)
            gray_state <= 1'b0;
        else if (step)
            gray_state <= ser_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // decade chain
    logic [SBC_DECADES:0]   chain;
    logic [SBC_BCD_W-1:0]   digits;
    assign chain[0] = ser_bit;

    genvar g;
    generate
        for (g = 0; g < SBC_DECADES; g++)
        begin : g_dec
            sbc_decade u_dec (
                .clock_i (clock_i),
                .srst_i  (srst_i),
                .clr_i   (convert_rise),
                .step_i  (step),
                .bit_i   (chain[g]),
                .bit_o   (chain[g+1]),
                .digit_o (digits[4*g +: 4])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // outputs from flops; bcd follows the decades and holds when idle
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            bcd_o  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            bcd_o  <= digits;
            busy_o <= run;
            done_o <= step && last_pulse(pulse_cnt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    load_after_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
        enter_rise && entry_st == SBC_IDLE |=> entry_st == SBC_CLEAR ##1 entry_st == SBC_LOAD)
        else $error("load not preceded by clear");
    load_takes_word_a: assert property (@(posedge clock_i) disable iff (srst_i)
        entry_st == SBC_LOAD |=> shreg == $past(word_s))
        else $error("entry register missed word");
    convert_starts_a: assert property (@(posedge clock_i) disable iff (srst_i)
        convert_rise |=> run && pulse_cnt == SBC_CNT_ZERO && digits == '0 && !gray_state)
        else $error("convert did not reset state");
    burst_stops_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && last_pulse(pulse_cnt) && !convert_rise |=> !run)
        else $error("burst did not stop at twelve");
    burst_count_a: assert property (@(posedge clock_i) disable iff (srst_i)
        $fell(run) |-> step_seen == SBC_BURST_LEN)
        else $error("burst length not twelve pulses");
    shift_entry_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && entry_st == SBC_IDLE |=> shreg[0] == 1'b0 && shreg[SBC_WORD_W-1:1] == $past(shreg[SBC_WORD_W-2:0]))
        else $error("entry register did not shift");
    low_decade_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise && digits[3:0] < SBC_ADD_LIMIT |=> digits[3:0] == {$past(digits[2:0]), $past(ser_bit)})
        else $error("low decade shift wrong");
    carry_chain_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise |=> digits[4] == $past(chain[1]))
        else $error("carry not passed upward");
    hold_result_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !step && !convert_rise |=> digits == $past(digits))
        else $error("result changed without pulse");
    gray_xor_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise && cmd_s.gray_mode |=> gray_state == ($past(gray_state) ^ $past(src_bit)))
        else $error("gray decode wrong");

    // entry side
    word_freeze_a: assert property (@(posedge clock_i) disable iff (srst_i)
        cmd_s.enter |=> $stable(word_s))
        else $error("entry word moved while enter held");
    entry_once_a: assert property (@(posedge clock_i) disable iff (srst_i)
        entry_st == SBC_LOAD |=> entry_st == SBC_IDLE)
        else $error("entry load pulse too long");
    clear_zero_a: assert property (@(posedge clock_i) disable iff (srst_i)
        entry_st == SBC_CLEAR |=> shreg == '0)
        else $error("entry register not cleared");

    // burst side
    osc_spacing_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !cmd_s.ext_clk_sel |=> (!step) [*3])
        else $error("internal pulses too close");
    ext_count_a: assert property (@(posedge clock_i) disable iff (srst_i)
        run && cmd_s.ext_clk_sel && ext_rise && !convert_rise && !last_pulse(pulse_cnt)
            |=> pulse_cnt == $past(pulse_cnt) + 1'b1)
        else $error("external pulse not counted");
    done_pulse_a: assert property (@(posedge clock_i) disable iff (srst_i)
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_ends_burst_a: assert property (@(posedge clock_i) disable iff (srst_i)
        done_o && !$past(convert_rise) |-> !run)
        else $error("burst still running after done");
    busy_follows_a: assert property (@(posedge clock_i) disable iff (srst_i)
        1'b1 |=> busy_o == $past(run))
        else $error("busy does not track run flag");

    // decade side
    add_three_carry_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise && digits[3:0] >= SBC_ADD_LIMIT |=> digits[4])
        else $error("five or more gave no carry");
    bcd_digits_a: assert property (@(posedge clock_i) disable iff (srst_i)
        is_bcd(digits[3:0]) && is_bcd(digits[7:4]) && is_bcd(digits[11:8]) && is_bcd(digits[15:12]))
        else $error("decade left bcd range");
    gray_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise && !cmd_s.gray_mode |=> digits[0] == $past(src_bit))
        else $error("binary bit altered outside gray mode");
    serial_path_a: assert property (@(posedge clock_i) disable iff (srst_i)
        step && !convert_rise && cmd_s.serial_sel && !cmd_s.gray_mode |=> digits[0] == $past(cmd_s.serial_in))
        else $error("serial input not shifted in");

    // outputs
    result_out_a: assert property (@(posedge clock_i) disable iff (srst_i)
        1'b1 |=> bcd_o == $past(digits))
        else $error("bcd output does not follow decades");
endmodule
`default_nettype wire

// ---- testbench/sbc_upstream.sv ----
/*
  sbc_upstream: model of the upstream equipment that drives words and commands.
  assumes the bench calls its tasks at a falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_upstream
    import sbc_pkg::*;
(
    // clock
    input  wire logic               clock_i,
    // commands and word to the converter
    output var sbc_cmd_s            cmd_o,
    output logic [SBC_WORD_W-1:0]   word_o
);
    initial
    begin
        cmd_o  = '0;
        word_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // word settles before enter, since enter freezes the sampled copy
    task automatic load(input logic [SBC_WORD_W-1:0] w);
        word_o = w;
        idle(4);
        cmd_o.enter = 1'b1;
        idle(4);
        cmd_o.enter = 1'b0;
        word_o      = ~w;
        idle(4);
    endtask
    task automatic convert();
        cmd_o.convert = 1'b1;
        idle(2);
        cmd_o.convert = 1'b0;
    endtask
    task automatic mode(input logic gray, input logic ext, input logic ser);
        cmd_o.gray_mode   = gray;
        cmd_o.ext_clk_sel = ext;
        cmd_o.serial_sel  = ser;
    endtask
    // bit stays through the whole pulse, then the line no longer holds it
    task automatic pulse(input logic b);
        cmd_o.serial_in = b;
        idle(2);
        cmd_o.ext_clk = 1'b1;
        idle(3);
        cmd_o.ext_clk = 1'b0;
        idle(2);
        cmd_o.serial_in = ~b;
        idle(1);
    endtask
endmodule
`default_nettype wire

// ---- testbench/sbc_top_tb_top.sv ----
/*
  sbc_top_tb_top: self-checking bench for the serial binary-to-bcd converter.
  assumes the upstream model in sbc_upstream and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_top_tb_top;
    import sbc_pkg::*;
    logic                   clock_i;
    logic                   srst_i;
    sbc_cmd_s               cmd;
    logic [SBC_WORD_W-1:0]  word;
    logic [SBC_BCD_W-1:0]   bcd_o;
    logic                   busy_o;
    logic                   done_o;
    int                     num_errors;
    int                     compares;
    sbc_top uut (.clock_i(clock_i), .srst_i(srst_i), .cmd_i(cmd), .word_i(word),
                 .bcd_o(bcd_o), .busy_o(busy_o), .done_o(done_o));
    sbc_upstream up (.clock_i(clock_i), .cmd_o(cmd), .word_o(word));
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [15:0] to_bcd(input int v);
        return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    function automatic int from_gray(input logic [11:0] g);
        logic [11:0] b;
        b[11] = g[11];
        for (int i = 10; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return int'(b);
    endfunction
    task automatic wait_sig(input int lim, input bit on_done);
        for (int i = 0; i < lim && (on_done ? done_o : busy_o) !== 1'b1; i++)
            up.idle(1);
    endtask
    // convert clears the result, burst runs, result holds afterwards
    task automatic run_int(input logic [11:0] w, input logic gray);
        up.mode(gray, 1'b0, 1'b0);
        up.load(w);
        up.convert();
        wait_sig(20, 1'b0);
        check(16'(busy_o), 16'h1);
        check(bcd_o, 16'h0);
        wait_sig(60, 1'b1);
        check(16'(done_o), 16'h1);
        // bcd_o is registered one cycle behind the last decade shift
        up.idle(1);
        check(bcd_o, to_bcd(gray ? from_gray(w) : int'(w)));
        check({14'h0, done_o, busy_o}, 16'h0);
        up.idle(20);
        check(bcd_o, to_bcd(gray ? from_gray(w) : int'(w)));
    endtask
    // eleven pulses leave the burst open, the twelfth ends it
    task automatic run_ext(input logic [11:0] w, input logic gray, input logic ser);
        up.mode(gray, 1'b1, ser);
        if (!ser)
            up.load(w);
        up.convert();
        wait_sig(20, 1'b0);
        for (int i = 11; i >= 1; i--)
            up.pulse(w[i]);
        check({14'h0, done_o, busy_o}, 16'h1);
        up.pulse(w[0]);
        check(bcd_o, to_bcd(gray ? from_gray(w) : int'(w)));
        check(16'(busy_o), 16'h0);
        up.pulse(1'b1);
        up.pulse(1'b1);
        check(bcd_o, to_bcd(gray ? from_gray(w) : int'(w)));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        num_errors = 0;
        compares   = 0;
        srst_i     = 1'b1;
        repeat (12) @(negedge clock_i);
        srst_i = 1'b0;
        up.idle(1);
        check({bcd_o[13:0], done_o, busy_o}, 16'h0);
        // zero word after the full one catches stale entry bits
        run_int(12'hFFF, 1'b0);
        run_int(12'h000, 1'b0);
        run_int(12'h3E7, 1'b0);
        run_int(12'h3E8, 1'b0);
        run_int(12'h800, 1'b1);
        run_int(12'hABC, 1'b1);
        run_ext(12'h5A5, 1'b0, 1'b0);
        run_ext(12'hC35, 1'b0, 1'b1);
        run_ext(12'h9F1, 1'b1, 1'b1);
        end_sim();
    end
    // whole run is under three thousand cycles
    initial
    begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
